// ==== hw/typeb_defines.vh ====
`ifndef TYPEB_DEFINES_VH
`define TYPEB_DEFINES_VH

// ****************************************************
// register offsets
// ****************************************************
`define ADDR_W 6
`define OFS_RX_TUNING 6'h1d
`define OFS_TYPEB_CTRL 6'h1e
`define OFS_TYPEB_STATUS 6'h3e

// ****************************************************
// reset values and writable masks
// ****************************************************
`define RST_RX_TUNING 8'h00
`define RST_TYPEB_CTRL 8'h00
`define MASK_RX_TUNING 8'h7f
`define MASK_TYPEB_CTRL 8'hdf

// ****************************************************
// receiver tuning fields
// ****************************************************
`define BIT_FAST_FILT 6
`define BIT_SIG_DELAY 5
`define BIT_PARITY_OFF 4
`define BIT_WIDE_PLL 3
`define BIT_MANUAL_CORNER 2
`define CORNER_HI 1
`define CORNER_LO 0

// ****************************************************
// type b control fields
// ****************************************************
`define BIT_SOF_REQ 7
`define BIT_EOF_REQ 6
`define BIT_MARKER_WIDTH 4
`define BIT_NO_TX_SOF 3
`define BIT_NO_TX_EOF 2
`define EGT_HI 1
`define EGT_LO 0

// ****************************************************
// marker timing, in etu and carrier cycles
// ****************************************************
`define ETU_FC 128
`define SOF_LOW_MIN_ETU 10
`define SOF_LOW_MAX_ETU 11
`define SOF_HIGH_MIN_ETU 2
`define SOF_HIGH_MAX_ETU 3
`define ADJ_TRIM_FC 8

`endif

// ==== hw/marker_gen.v ====
`include "typeb_defines.vh"

// ****************************************************
// transmit marker and guard time sequencer
// ****************************************************
module marker_gen #(
  parameter ETU = `ETU_FC
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_fc_tick,
  input wire i_frame_start,
  input wire i_char_end,
  input wire i_frame_end,
  input wire i_no_sof,
  input wire i_no_eof,
  input wire i_width_max,
  input wire i_adjust,
  input wire [1:0] i_egt,
  output reg o_mod_low,
  output reg o_data_phase,
  output reg [2:0] o_phase
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_SOF_LO = 3'd1;
  localparam [2:0] S_SOF_HI = 3'd2;
  localparam [2:0] S_DATA = 3'd3;
  localparam [2:0] S_GUARD = 3'd4;
  localparam [2:0] S_EOF_LO = 3'd5;
  localparam [11:0] ETU12 = ETU;

  reg [11:0] cnt_r;
  reg [11:0] low_len;
  reg [11:0] high_len;

  // marker lengths from width and adjust
  always @* begin
    if (i_width_max && i_adjust) begin
      low_len = 12'd11 * ETU12 - 12'd`ADJ_TRIM_FC;
      high_len = 12'd2 * ETU12 + 12'd`ADJ_TRIM_FC;
    end else if (i_width_max) begin
      low_len = 12'd`SOF_LOW_MAX_ETU * ETU12;
      high_len = 12'd`SOF_HIGH_MAX_ETU * ETU12;
    end else begin
      low_len = 12'd`SOF_LOW_MIN_ETU * ETU12;
      high_len = 12'd`SOF_HIGH_MIN_ETU * ETU12;
    end
  end

  // sequencer, counting carrier cycles
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase <= S_IDLE;
      cnt_r <= 12'h000;
      o_mod_low <= 1'b0;
      o_data_phase <= 1'b0;
    end else begin
      case (o_phase)
        S_IDLE: begin
          if (i_frame_start && i_no_sof) begin
            o_phase <= S_DATA;
            o_data_phase <= 1'b1;
          end else if (i_frame_start) begin
            o_phase <= S_SOF_LO;
            o_mod_low <= 1'b1;
            cnt_r <= low_len;
          end
        end
        S_SOF_LO, S_SOF_HI, S_GUARD, S_EOF_LO: begin
          if (i_fc_tick && cnt_r <= 12'h001) begin
            o_mod_low <= 1'b0;
            if (o_phase == S_SOF_LO) begin
              o_phase <= S_SOF_HI;
              cnt_r <= high_len;
            end else if (o_phase == S_EOF_LO) begin
              o_phase <= S_IDLE;
            end else begin
              o_phase <= S_DATA;
              o_data_phase <= 1'b1;
            end
          end else if (i_fc_tick) begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        S_DATA: begin
          if (i_frame_end) begin
            o_data_phase <= 1'b0;
            o_phase <= i_no_eof ? S_IDLE : S_EOF_LO;
            o_mod_low <= !i_no_eof;
            cnt_r <= low_len;
          end else if (i_char_end && i_egt != 2'b00) begin
            o_data_phase <= 1'b0;
            o_phase <= S_GUARD;
            cnt_r <= {10'h000, i_egt} * ETU12;
          end
        end
        default: begin
          o_phase <= S_IDLE;
          o_mod_low <= 1'b0;
          o_data_phase <= 1'b0;
        end
      endcase
    end
  end
endmodule // marker_gen

// ==== hw/rx_frame_filter.v ====
`include "typeb_defines.vh"

// ****************************************************
// receive marker check and stripping
// ****************************************************
module rx_frame_filter (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_sof_req,
  input wire i_eof_req,
  input wire i_rx_sof,
  input wire i_rx_byte_valid,
  input wire [7:0] i_rx_byte,
  input wire i_rx_eof,
  input wire i_rx_stream_end,
  output reg o_fifo_wr,
  output reg [7:0] o_fifo_data,
  output reg o_proto_err,
  output reg [1:0] o_state
);
  localparam [1:0] R_IDLE = 2'd0;
  localparam [1:0] R_FRAME = 2'd1;
  localparam [1:0] R_DROP = 2'd2;

  // markers never reach the fifo; only data bytes are written
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state <= R_IDLE;
      o_fifo_wr <= 1'b0;
      o_fifo_data <= 8'h00;
      o_proto_err <= 1'b0;
    end else begin
      o_fifo_wr <= 1'b0;
      o_proto_err <= 1'b0;
      case (o_state)
        R_IDLE: begin
          if (i_rx_sof) begin
            o_state <= R_FRAME;
          end else if (i_rx_byte_valid && i_sof_req) begin
            o_state <= R_DROP;
          end else if (i_rx_byte_valid) begin
            o_state <= R_FRAME;
            o_fifo_wr <= 1'b1;
            o_fifo_data <= i_rx_byte;
          end
        end
        R_FRAME: begin
          if (i_rx_eof) begin
            o_state <= R_IDLE;
          end else if (i_rx_stream_end) begin
            o_state <= R_IDLE;
            o_proto_err <= i_eof_req;
          end else if (i_rx_byte_valid) begin
            o_fifo_wr <= 1'b1;
            o_fifo_data <= i_rx_byte;
          end
        end
        R_DROP: begin
          if (i_rx_eof || i_rx_stream_end) begin
            o_state <= R_IDLE;
          end
        end
        default: begin
          o_state <= R_IDLE;
        end
      endcase
    end
  end
endmodule // rx_frame_filter

// ==== hw/typeb_framing_rx_tuning.v ====
// What this block does
// - fast-filter bit set switches the miller delay filter to fast mode
// - output-delay bit delays signal output by 128 carrier cycles
// - parity-off bit stops parity generation and checking; parity becomes data
// - wide-pll bit extends clock-recovery pll bandwidth
// - manual-corner bit 0 uses automatic corner; 1 applies the field
// - corner field 00..11 selects 106, 212, 424 or 848 khz
// - start-marker-required set discards streams lacking a start marker
// - start-marker-required clear accepts both and strips the marker
// - end-marker-required set flags protocol error when end marker missing
// - end-marker-required clear accepts both and strips the end marker
// - without adjust, width bit picks maximum or minimum marker length
// - width and adjust set give 11 etu-8, 2 etu+8, 11 etu-8
// - suppress-start bit sends frames without start marker
// - suppress-end bit sends frames without end marker
// - guard field gives 0 to 3 extra guard bits between characters

`include "typeb_defines.vh"

module typeb_framing_rx_tuning #(
  parameter ETU = `ETU_FC
) (
  input wire i_core_clk,
  input wire i_rst_n,
  // register port
  input wire [`ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // receiver chain controls
  input wire [1:0] i_rx_speed,
  output reg o_fast_miller_filter,
  output reg o_sig_output_delay,
  output reg o_parity_gen_en,
  output reg o_parity_check_en,
  output reg o_wide_pll_bandwidth,
  output reg [1:0] o_highpass_corner,
  // transmit framing
  input wire i_fc_tick,
  input wire i_marker_adjust,
  input wire i_tx_frame_start,
  input wire i_tx_char_end,
  input wire i_tx_frame_end,
  output wire o_tx_mod_low,
  output wire o_tx_data_phase,
  // receive framing
  input wire i_rx_sof,
  input wire i_rx_byte_valid,
  input wire [7:0] i_rx_byte,
  input wire i_rx_eof,
  input wire i_rx_stream_end,
  output wire o_fifo_wr,
  output wire [7:0] o_fifo_data,
  output wire o_proto_err
);

  // ****************************************************
  // registers
  // ****************************************************
  reg [7:0] rx_tuning_r;
  reg [7:0] typeb_ctrl_r;
  reg [7:0] rd_nxt;
  reg proto_err_seen_r;
  wire [2:0] tx_phase;
  wire [1:0] rx_state;

  // software writes; reserved bits never stored
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_tuning_r <= `RST_RX_TUNING;
      typeb_ctrl_r <= `RST_TYPEB_CTRL;
    end else if (i_wr) begin
      if (i_addr == `OFS_RX_TUNING) begin
        rx_tuning_r <= i_wdata & `MASK_RX_TUNING;
      end
      if (i_addr == `OFS_TYPEB_CTRL) begin
        typeb_ctrl_r <= i_wdata & `MASK_TYPEB_CTRL;
      end
    end
  end

  // sticky error seen, cleared by status read; a new error wins
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      proto_err_seen_r <= 1'b0;
    end else if (o_proto_err) begin
      proto_err_seen_r <= 1'b1;
    end else if (i_rd && i_addr == `OFS_TYPEB_STATUS) begin
      proto_err_seen_r <= 1'b0;
    end
  end

  // read mux; unmapped reads return zero
  always @* begin
    case (i_addr)
      `OFS_RX_TUNING: rd_nxt = rx_tuning_r;
      `OFS_TYPEB_CTRL: rd_nxt = typeb_ctrl_r;
      `OFS_TYPEB_STATUS: rd_nxt = {2'b00, proto_err_seen_r, rx_state, tx_phase};
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_nxt;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ****************************************************
  // receiver tuning outputs
  // ****************************************************
  reg [1:0] auto_corner;

  // automatic corner follows the receive rate
  always @* begin
    auto_corner = i_rx_speed;
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fast_miller_filter <= 1'b0;
      o_sig_output_delay <= 1'b0;
      o_parity_gen_en <= 1'b1;
      o_parity_check_en <= 1'b1;
      o_wide_pll_bandwidth <= 1'b0;
      o_highpass_corner <= 2'b00;
    end else begin
      o_fast_miller_filter <= rx_tuning_r[`BIT_FAST_FILT];
      o_sig_output_delay <= rx_tuning_r[`BIT_SIG_DELAY];
      o_parity_gen_en <= !rx_tuning_r[`BIT_PARITY_OFF];
      o_parity_check_en <= !rx_tuning_r[`BIT_PARITY_OFF];
      o_wide_pll_bandwidth <= rx_tuning_r[`BIT_WIDE_PLL];
      if (rx_tuning_r[`BIT_MANUAL_CORNER]) begin
        o_highpass_corner <= rx_tuning_r[`CORNER_HI:`CORNER_LO];
      end else begin
        o_highpass_corner <= auto_corner;
      end
    end
  end

  // ****************************************************
  // transmit markers and guard time
  // ****************************************************
  // width bit selects maximum or minimum length; adjust trims the maximum
  marker_gen #(
    .ETU(ETU)
  ) u_marker_gen (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_fc_tick(i_fc_tick),
    .i_frame_start(i_tx_frame_start),
    .i_char_end(i_tx_char_end),
    .i_frame_end(i_tx_frame_end),
    .i_no_sof(typeb_ctrl_r[`BIT_NO_TX_SOF]),
    .i_no_eof(typeb_ctrl_r[`BIT_NO_TX_EOF]),
    .i_width_max(typeb_ctrl_r[`BIT_MARKER_WIDTH]),
    .i_adjust(i_marker_adjust),
    .i_egt(typeb_ctrl_r[`EGT_HI:`EGT_LO]),
    .o_mod_low(o_tx_mod_low),
    .o_data_phase(o_tx_data_phase),
    .o_phase(tx_phase)
  );

  // ****************************************************
  // receive marker handling
  // ****************************************************
  // drop streams without start marker
  rx_frame_filter u_rx_frame_filter (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_sof_req(typeb_ctrl_r[`BIT_SOF_REQ]),
    .i_eof_req(typeb_ctrl_r[`BIT_EOF_REQ]),
    .i_rx_sof(i_rx_sof),
    .i_rx_byte_valid(i_rx_byte_valid),
    .i_rx_byte(i_rx_byte),
    .i_rx_eof(i_rx_eof),
    .i_rx_stream_end(i_rx_stream_end),
    .o_fifo_wr(o_fifo_wr),
    .o_fifo_data(o_fifo_data),
    .o_proto_err(o_proto_err),
    .o_state(rx_state)
  );

endmodule // typeb_framing_rx_tuning

// ==== dv/typeb_framing_rx_tuning_asserts.sv ====
module typeb_checker #(
  parameter int ETU = 128
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [5:0] i_addr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_parity_gen_en,
  input wire o_parity_check_en,
  input wire i_rx_byte_valid,
  input wire [7:0] i_rx_byte,
  input wire i_rx_stream_end,
  input wire o_fifo_wr,
  input wire [7:0] o_fifo_data,
  input wire o_proto_err,
  input wire o_tx_mod_low,
  input wire o_tx_data_phase
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOW_MIN = (10 * ETU < 11 * ETU - 8) ? 10 * ETU : 11 * ETU - 8;
  logic [15:0] low_cnt_r;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // length of the current low period
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt_r <= 16'h0000;
    else if (o_tx_mod_low) low_cnt_r <= low_cnt_r + 16'h0001;
    else low_cnt_r <= 16'h0000;
  end
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) // read answer only
    else $error("read data not zero outside a read answer");
  chk_rsvd_tune: assert property ($past(i_rd) && $past(i_addr) == 6'h1d |-> !o_rdata[7])
    else $error("tuning reserved bit reads one");
  chk_rsvd_ctrl: assert property ($past(i_rd) && $past(i_addr) == 6'h1e |-> !o_rdata[5])
    else $error("control reserved bit reads one");
  chk_parity_pair: assert property (o_parity_gen_en == o_parity_check_en)
    else $error("parity enables differ");
  chk_fifo_copy: assert property (o_fifo_wr |-> $past(i_rx_byte_valid) && o_fifo_data == $past(i_rx_byte))
    else $error("fifo write without a received byte");
  chk_err_cause: assert property (o_proto_err |-> $past(i_rx_stream_end))
    else $error("protocol error without stream end");
  chk_tx_excl: assert property (!(o_tx_mod_low && o_tx_data_phase))
    else $error("marker low during data phase");
  chk_low_min: assert property ($fell(o_tx_mod_low) |-> low_cnt_r >= LOW_MIN)
    else $error("marker low period too short");
endmodule // typeb_checker

bind typeb_framing_rx_tuning typeb_checker #(.ETU(ETU)) u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_parity_gen_en(o_parity_gen_en),
  .o_parity_check_en(o_parity_check_en), .i_rx_byte_valid(i_rx_byte_valid),
  .i_rx_byte(i_rx_byte), .i_rx_stream_end(i_rx_stream_end), .o_fifo_wr(o_fifo_wr),
  .o_fifo_data(o_fifo_data), .o_proto_err(o_proto_err), .o_tx_mod_low(o_tx_mod_low),
  .o_tx_data_phase(o_tx_data_phase)
);

// ==== dv/rf_peer_model.sv ====
module rf_peer_model (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_go,
  input wire i_with_sof,
  input wire i_with_eof,
  input wire [7:0] i_byte,
  output logic o_fc_tick,
  output wire o_rx_sof,
  output wire o_rx_byte_valid,
  output wire [7:0] o_rx_byte,
  output wire o_rx_eof,
  output wire o_rx_stream_end
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] step_r;
  // carrier tick and frame step counter
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_r <= 3'h0;
      o_fc_tick <= 1'b0;
    end else begin
      o_fc_tick <= 1'b1;
      if (i_go) step_r <= 3'h1;
      else if (step_r != 3'h0) step_r <= (step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
    end
  end
  // markers optional, byte line inverted when not valid
  assign o_rx_sof = (step_r == 3'h1) && i_with_sof;
  assign o_rx_byte_valid = (step_r == 3'h2);
  assign o_rx_byte = (step_r == 3'h2) ? i_byte : ~i_byte;
  assign o_rx_eof = (step_r == 3'h3) && i_with_eof;
  assign o_rx_stream_end = (step_r == 3'h4);
endmodule // rf_peer_model

// ==== dv/typeb_framing_rx_tuning_tb.sv ====
module typeb_framing_rx_tuning_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ETU = 4;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [5:0] i_addr = 6'h00;
  logic [7:0] i_wdata = 8'h00, rx_val = 8'h00, last_data = 8'h00;
  logic [1:0] i_rx_speed = 2'h0;
  logic i_marker_adjust = 1'b0, tx_start = 1'b0, tx_char = 1'b0, tx_end = 1'b0;
  logic go = 1'b0, with_sof = 1'b0, with_eof = 1'b0;
  wire fc_tick, rx_sof, rx_bv, rx_eof, rx_end, fast, sdly, pgen, pchk, wide;
  wire mod_low, data_ph, fifo_wr, perr;
  wire [7:0] rx_byte, o_rdata, fifo_data;
  wire [1:0] corner;
  int n_mismatch = 0, num_checks = 0, n_wr = 0, n_err = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  typeb_framing_rx_tuning #(.ETU(ETU)) uut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_speed(i_rx_speed),
    .o_fast_miller_filter(fast), .o_sig_output_delay(sdly), .o_parity_gen_en(pgen),
    .o_parity_check_en(pchk), .o_wide_pll_bandwidth(wide), .o_highpass_corner(corner),
    .i_fc_tick(fc_tick), .i_marker_adjust(i_marker_adjust), .i_tx_frame_start(tx_start),
    .i_tx_char_end(tx_char), .i_tx_frame_end(tx_end), .o_tx_mod_low(mod_low),
    .o_tx_data_phase(data_ph), .i_rx_sof(rx_sof), .i_rx_byte_valid(rx_bv),
    .i_rx_byte(rx_byte), .i_rx_eof(rx_eof), .i_rx_stream_end(rx_end),
    .o_fifo_wr(fifo_wr), .o_fifo_data(fifo_data), .o_proto_err(perr)
  );
  rf_peer_model peer (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_go(go), .i_with_sof(with_sof),
    .i_with_eof(with_eof), .i_byte(rx_val), .o_fc_tick(fc_tick), .o_rx_sof(rx_sof),
    .o_rx_byte_valid(rx_bv), .o_rx_byte(rx_byte), .o_rx_eof(rx_eof),
    .o_rx_stream_end(rx_end)
  );

  // fifo write and error monitor
  always @(negedge i_core_clk) begin
    if (fifo_wr === 1'b1) begin
      n_wr++;
      last_data = fifo_data;
    end
    if (perr === 1'b1) n_err++;
  end

  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task ts_chk(input logic [6:0] e);
    @(posedge i_core_clk);
    #1 chk({fast, sdly, pgen, pchk, wide, corner}, e);
  endtask
  task tx_pulse(input int k);
    @(posedge i_core_clk);
    tx_start <= (k == 0); tx_char <= (k == 1); tx_end <= (k == 2);
    @(posedge i_core_clk);
    {tx_start, tx_char, tx_end} <= 3'b000;
    #1;
  endtask
  // cycles spent low (sel 0) or outside data phase (sel 1)
  task span(input int sel, output int n);
    n = 0;
    while (((sel == 0) ? mod_low : ~data_ph) === 1'b1) begin
      @(posedge i_core_clk);
      #1 n++;
      if (n > 3000) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask
  task tx_case(input logic [7:0] c, input logic adj, input int el, input int eh);
    int n;
    wr(6'h1e, c);
    i_marker_adjust <= adj;
    tx_pulse(0);
    span(0, n); chk(n, c[3] ? 0 : el);
    span(1, n); chk(n, c[3] ? 0 : eh);
    tx_pulse(1);
    span(1, n); chk(n, c[1:0] * ETU);
    tx_pulse(2);
    span(0, n); chk(n, c[2] ? 0 : el);
    chk(data_ph, 0);
  endtask
  task rx_case(input logic [7:0] c, input logic s, input logic e, input int ew, input int ee);
    wr(6'h1e, c);
    with_sof <= s; with_eof <= e; rx_val <= rx_val + 8'h3b;
    n_wr = 0; n_err = 0; last_data = 8'h00;
    @(posedge i_core_clk);
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    chk(n_wr, ew); chk(n_err, ee); chk(last_data, ew ? rx_val : 8'h00);
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1 chk({pgen, pchk}, 2'h3);
    rd(6'h1d, 8'h00); rd(6'h1e, 8'h00); rd(6'h00, 8'h00);
    wr(6'h1d, 8'hff); rd(6'h1d, 8'h7f);
    wr(6'h1e, 8'hff); rd(6'h1e, 8'hdf);
    i_rx_speed <= 2'h2;
    for (int b = 3; b < 7; b++) begin
      wr(6'h1d, 8'h01 << b);
      ts_chk({b == 6, b == 5, b != 4, b != 4, b == 3, 2'h2});
    end
    for (int c = 0; c < 4; c++) begin
      wr(6'h1d, 8'h04 | c);
      ts_chk({5'b00110, 2'(c)});
    end
    tx_case(8'h10, 1'b1, 11 * ETU - 8, 2 * ETU + 8);
    tx_case(8'h00, 1'b0, 10 * ETU, 2 * ETU);
    tx_case(8'h13, 1'b0, 11 * ETU, 3 * ETU);
    tx_case(8'h09, 1'b0, 10 * ETU, 2 * ETU);
    tx_case(8'h06, 1'b0, 10 * ETU, 2 * ETU);
    rx_case(8'h00, 1'b1, 1'b1, 1, 0);
    rx_case(8'h00, 1'b0, 1'b0, 1, 0);
    rx_case(8'h80, 1'b0, 1'b1, 0, 0);
    rx_case(8'h80, 1'b1, 1'b1, 1, 0);
    rx_case(8'h40, 1'b1, 1'b0, 1, 1);
    rd(6'h3e, 8'h20); rd(6'h3e, 8'h00);
    rx_case(8'h40, 1'b1, 1'b1, 1, 0);
    print_verdict();
  end
endmodule // typeb_framing_rx_tuning_tb
